/* bdma_core.sv */
// Summary of operation
// RULE1: every location holds eight bits
// RULE2: two banks, eeprom control only bank one
// RULE3: 128 general bytes at 80h-ffh bank zero
// RULE4: unused locations read zero, store nothing
// RULE5: read-only registers ignore program writes
// RULE6: window access redirects through paired pointer
// RULE7: first window pair always reaches bank zero
// RULE8: second window pair uses selected bank
// RULE9: pointer at window: read zero, write nothing
// RULE10: pointers are ordinary read-write registers
// RULE11: direct access always reaches bank zero
// RULE12: special registers start at address 00h
// RULE13: single bit set or clear supported
// RULE14: bank chosen by bank select bit zero
// RULE15: reset selects bank zero except wdt sleep
// RULE16: full eight-bit pointer addresses bank
`timescale 1ns/1ps
module bdma_core
	import bdma_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wdt_sleep_rst,
	// access request from the execution core
	input wire logic acc_rd,
	input wire logic acc_wr,
	input wire logic [7:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	input wire logic bit_op,
	input wire logic [2:0] bit_sel,
	input wire logic bit_val,
	// read data back to the core
	output logic [7:0] acc_rdata,
	// external special registers (other blocks)
	output logic sfr_sel,
	output logic sfr_wr,
	output logic sfr_bank,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic sfr_ro,
	// state visible to the core
	output logic [7:0] ptr0_q,
	output logic [7:0] ptr1_q,
	output logic bank_q
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] gp_mem [0:BDMA_GP_DEPTH-1];
	logic [7:0] ptr0_r, ptr0_nxt;
	logic [7:0] ptr1_r, ptr1_nxt;
	logic bank_r, bank_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic sel_r, sel_nxt, wr_r, wr_nxt, sbank_r, sbank_nxt;
	logic [7:0] saddr_r, saddr_nxt, swdata_r, swdata_nxt;
	logic [7:0] eff_addr;
	logic eff_bank, eff_null, gp_we;
	logic [7:0] own_rd, wval;
	logic own_hit;
	// a forwarded read whose answer is taken in the next cycle
	logic ext_rd_r, ext_rd_nxt;

	// true when an address is one of the two window locations
	function automatic logic is_win(input logic [7:0] a);
		is_win = (a == BDMA_WIN0_ADDR) || (a == BDMA_WIN1_ADDR);
	endfunction : is_win

	// ----------------------------------------
	// address resolution
	// ----------------------------------------
	always_comb begin
		eff_addr = acc_addr;
		eff_bank = 1'b0;
		eff_null = 1'b0;
		// RULE11: direct to bank zero
		// RULE6: window redirects via pointer
		// RULE16: whole pointer is the address
		if (acc_addr == BDMA_WIN0_ADDR) begin
			eff_addr = ptr0_r;
			// RULE7: window zero bank zero
			eff_bank = 1'b0;
			// RULE9: pointer at window nulls
			eff_null = is_win(ptr0_r);
		end else if (acc_addr == BDMA_WIN1_ADDR) begin
			eff_addr = ptr1_r;
			// RULE8: window one follows bank
			eff_bank = bank_r;
			eff_null = is_win(ptr1_r);
		end
	end

	// ----------------------------------------
	// local registers read mux and write value
	// ----------------------------------------
	always_comb begin
		own_rd = BDMA_ZERO;
		own_hit = 1'b0;
		// RULE12: map starts at 00h
		if (eff_addr == BDMA_PTR0_ADDR) begin
			own_rd = ptr0_r;
			own_hit = 1'b1;
		end else if (eff_addr == BDMA_PTR1_ADDR) begin
			own_rd = ptr1_r;
			own_hit = 1'b1;
		end else if (eff_addr == BDMA_BANK_ADDR) begin
			// RULE14: upper bits read zero
			own_rd = {7'h00, bank_r};
			own_hit = 1'b1;
		end else if (eff_addr >= BDMA_GP_BASE) begin
			// RULE3: general area bank zero only
			own_rd = eff_bank ? BDMA_ZERO : gp_mem[eff_addr[6:0]];
			own_hit = 1'b1;
		end
		wval = acc_wdata;
		// RULE13: single bit read-modify-write
		// external targets answer a cycle late, so for them the core
		// hands the current byte in acc_wdata and only the bit is forced
		if (bit_op) begin
			wval = own_hit ? own_rd : acc_wdata;
			wval[bit_sel] = bit_val;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		ptr0_nxt = ptr0_r;
		ptr1_nxt = ptr1_r;
		bank_nxt = bank_r;
		rdata_nxt = rdata_r;
		gp_we = 1'b0;
		sel_nxt = 1'b0;
		wr_nxt = 1'b0;
		ext_rd_nxt = 1'b0;
		sbank_nxt = eff_bank;
		saddr_nxt = eff_addr;
		swdata_nxt = wval;
		if (rst && !wdt_sleep_rst) begin
			// RULE15: reset to bank zero
			bank_nxt = BDMA_BANK_RST;
		end
		// RULE4: external answer lands, unclaimed gives zero
		// the sfr answer belongs to the registered sfr_addr, so it is
		// only trusted in the cycle after the access was forwarded
		if (ext_rd_r)
			rdata_nxt = sfr_hit ? sfr_rdata : BDMA_ZERO;
		if (!rst && !eff_null && (acc_rd || acc_wr)) begin
			if (acc_rd) begin
				// own storage answers at once, others next cycle
				if (own_hit)
					rdata_nxt = own_rd;
				else
					rdata_nxt = BDMA_ZERO;
			end
			if (acc_wr) begin
				// RULE10: pointers are plain registers
				if (eff_addr == BDMA_PTR0_ADDR)
					ptr0_nxt = wval;
				else if (eff_addr == BDMA_PTR1_ADDR)
					ptr1_nxt = wval;
				else if (eff_addr == BDMA_BANK_ADDR)
					bank_nxt = wval[BDMA_BANK_BIT];
				else if (eff_addr >= BDMA_GP_BASE)
					gp_we = !eff_bank;
			end
			// RULE2: eeprom control bank one only
			if (!own_hit && !(eff_addr == BDMA_EEC_ADDR && !eff_bank)) begin
				sel_nxt = 1'b1;
				// RULE5: owner drops writes to protected cells
				// its sfr_ro flag is only valid once sfr_addr stands
				wr_nxt = acc_wr;
				ext_rd_nxt = acc_rd;
			end
		end else if (!rst && eff_null && acc_rd) begin
			rdata_nxt = BDMA_ZERO;
		end
		if (rst) begin
			ptr0_nxt = BDMA_PTR_RST;
			ptr1_nxt = BDMA_PTR_RST;
			rdata_nxt = BDMA_ZERO;
			gp_we = 1'b0;
			sel_nxt = 1'b0;
			wr_nxt = 1'b0;
			ext_rd_nxt = 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// RULE1: byte wide storage
	always_ff @(posedge clk_sys) begin
		ptr0_r <= ptr0_nxt;
		ptr1_r <= ptr1_nxt;
		bank_r <= bank_nxt;
		rdata_r <= rdata_nxt;
		sel_r <= sel_nxt;
		wr_r <= wr_nxt;
		ext_rd_r <= ext_rd_nxt;
		sbank_r <= sbank_nxt;
		saddr_r <= saddr_nxt;
		swdata_r <= swdata_nxt;
		if (gp_we)
			gp_mem[eff_addr[6:0]] <= wval;
	end

	// bank reg has no value before first reset; core must reset first
	assign acc_rdata = rdata_r;
	assign sfr_sel = sel_r;
	assign sfr_wr = wr_r;
	assign sfr_bank = sbank_r;
	assign sfr_addr = saddr_r;
	assign sfr_wdata = swdata_r;
	assign ptr0_q = ptr0_r;
	assign ptr1_q = ptr1_r;
	assign bank_q = bank_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	bank_upper_zero_a: assert property ( // RULE14
		acc_rd && !acc_wr && acc_addr == BDMA_BANK_ADDR
		|=> acc_rdata[7:1] == 7'h00)
		else $error("bank select upper bits not zero");
	win_null_read_a: assert property ( // RULE9
		acc_rd && acc_addr == BDMA_WIN0_ADDR && is_win(ptr0_r)
		|=> acc_rdata == BDMA_ZERO)
		else $error("window loop read not zero");
	ptr0_write_a: assert property ( // RULE10
		acc_wr && !bit_op && acc_addr == BDMA_PTR0_ADDR
		|=> ptr0_q == $past(acc_wdata))
		else $error("pointer zero not written");
	ptr1_via_win_a: assert property ( // RULE6
		acc_wr && !bit_op && acc_addr == BDMA_WIN1_ADDR
		&& ptr1_r == BDMA_PTR0_ADDR |=> ptr0_q == $past(acc_wdata))
		else $error("window did not redirect");
	win0_bank_a: assert property ( // RULE7
		acc_wr && acc_addr == BDMA_WIN0_ADDR && !is_win(ptr0_r)
		&& ptr0_r != BDMA_PTR0_ADDR && ptr0_r != BDMA_PTR1_ADDR
		&& ptr0_r != BDMA_BANK_ADDR |=> sfr_bank == 1'b0)
		else $error("window zero left bank zero");
	direct_bank_a: assert property ( // RULE11
		(acc_rd || acc_wr) && !is_win(acc_addr) |=> sfr_bank == 1'b0)
		else $error("direct access not bank zero");
	eec_bank0_a: assert property ( // RULE2
		acc_wr && acc_addr == BDMA_EEC_ADDR |=> !sfr_sel)
		else $error("eeprom control hit in bank zero");
	ro_write_a: assert property ( // RULE5
		acc_wr && !acc_rd && !bit_op && !is_win(acc_addr)
		&& acc_addr > BDMA_BANK_ADDR && acc_addr < BDMA_GP_BASE
		&& acc_addr != BDMA_EEC_ADDR
		|=> sfr_sel && sfr_wr && sfr_wdata == $past(acc_wdata))
		else $error("register write not offered to its owner");
	eec_bank1_a: assert property ( // RULE2
		(acc_rd || acc_wr) && acc_addr == BDMA_WIN1_ADDR && bank_r
		&& ptr1_r == BDMA_EEC_ADDR
		|=> sfr_sel && sfr_bank && sfr_addr == BDMA_EEC_ADDR)
		else $error("eeprom control not reached in bank one");
	ext_read_a: assert property ( // RULE4
		ext_rd_r && !acc_rd && sfr_hit |=> acc_rdata == $past(sfr_rdata))
		else $error("forwarded read answer lost");
	// reset checks must run while reset is high
	reset_bank_a: assert property ( // RULE15
		@(posedge clk_sys) disable iff (1'b0)
		rst && !wdt_sleep_rst |=> !bank_q)
		else $error("reset left bank one selected");
	keep_bank_a: assert property ( // RULE15
		@(posedge clk_sys) disable iff (1'b0)
		rst && wdt_sleep_rst |=> bank_q == $past(bank_q))
		else $error("watchdog sleep reset changed bank");
	gp_roundtrip_a: assert property ( // RULE3
		acc_wr && !bit_op && acc_addr >= BDMA_GP_BASE ##1
		acc_rd && !acc_wr && acc_addr == $past(acc_addr)
		|=> acc_rdata == $past(acc_wdata, 2))
		else $error("general byte lost");
	unused_zero_a: assert property ( // RULE4
		acc_rd && !acc_wr && !is_win(acc_addr) && acc_addr < BDMA_GP_BASE
		&& acc_addr > BDMA_BANK_ADDR ##1 !sfr_hit && !acc_rd
		|=> acc_rdata == BDMA_ZERO)
		else $error("unused location not zero");

	win1_cov_c: cover property (acc_rd && acc_addr == BDMA_WIN1_ADDR
		&& bank_r);
	bitop_cov_c: cover property (acc_wr && bit_op
		&& acc_addr >= BDMA_GP_BASE);
	null_cov_c: cover property (acc_wr && eff_null);
	eec_cov_c: cover property (sfr_sel && sfr_wr && sfr_bank
		&& sfr_addr == BDMA_EEC_ADDR);
	ext_rd_cov_c: cover property (ext_rd_r && sfr_hit);
endmodule : bdma_core

/* bdma_pkg.sv */
package bdma_pkg;
	// ----------------------------------------
	// addresses in the special function area
	// ----------------------------------------
	localparam logic [7:0] BDMA_WIN0_ADDR = 8'h00;
	localparam logic [7:0] BDMA_PTR0_ADDR = 8'h01;
	localparam logic [7:0] BDMA_WIN1_ADDR = 8'h02;
	localparam logic [7:0] BDMA_PTR1_ADDR = 8'h03;
	localparam logic [7:0] BDMA_BANK_ADDR = 8'h04;
	localparam logic [7:0] BDMA_EEC_ADDR = 8'h40;
	localparam logic [7:0] BDMA_GP_BASE = 8'h80;
	localparam logic [7:0] BDMA_ZERO = 8'h00;
	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] BDMA_PTR_RST = 8'h00;
	localparam logic BDMA_BANK_RST = 1'b0;
	localparam int BDMA_BANK_BIT = 0;
	localparam int BDMA_GP_DEPTH = 128;
endpackage : bdma_pkg

/* bdma_sfr_model.sv */
`timescale 1ns/1ps
// far side: a few external special registers behind the sfr_* ports
module bdma_sfr_model
	import bdma_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// request from the block
	input wire logic sfr_sel,
	input wire logic sfr_wr,
	input wire logic sfr_bank,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	// answer
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	output logic sfr_ro
);
	logic [7:0] mem_r [0:63];
	initial for (int i = 0; i < 64; i++) mem_r[i] = 8'ha5 ^ 8'(i);
	// decode; 40h only in bank 1
	always_comb begin
		sfr_hit = (sfr_addr >= 8'h05 && sfr_addr <= 8'h16) ||
			(sfr_addr == BDMA_EEC_ADDR && sfr_bank);
		sfr_ro = (sfr_addr == 8'h08);
		sfr_rdata = sfr_hit ? mem_r[sfr_addr[5:0]] : BDMA_ZERO;
	end
	// a protected cell keeps its value
	always @(posedge clk_sys) begin
		if (sfr_sel && sfr_wr && sfr_hit && !sfr_ro)
			mem_r[sfr_addr[5:0]] <= sfr_wdata;
	end
endmodule : bdma_sfr_model

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch t=%0t %h %h", $time, a, b); end end
module testbench;
	import bdma_pkg::*;
	logic clk_sys = 0, rst = 1, wdt_sleep_rst = 0, acc_rd = 0, acc_wr = 0;
	logic bit_op = 0, bit_val = 0, bank_q, sfr_sel, sfr_wr, sfr_bank;
	logic sfr_hit, sfr_ro;
	logic [2:0] bit_sel = 0;
	logic [7:0] acc_addr = 0, acc_wdata = 0, acc_rdata, sfr_addr, sfr_wdata;
	logic [7:0] sfr_rdata, ptr0_q, ptr1_q, a, d;
	logic [7:0] gp [0:127];
	logic [31:0] seed = 32'hfe37;
	int mismatches = 0, n_compared = 0, cyc = 0;
	always #50 clk_sys = ~clk_sys;
	bdma_core u_dut (.clk_sys(clk_sys), .rst(rst), .wdt_sleep_rst(wdt_sleep_rst),
		.acc_rd(acc_rd), .acc_wr(acc_wr), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .bit_op(bit_op), .bit_sel(bit_sel),
		.bit_val(bit_val), .acc_rdata(acc_rdata), .sfr_sel(sfr_sel),
		.sfr_wr(sfr_wr), .sfr_bank(sfr_bank), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.sfr_ro(sfr_ro), .ptr0_q(ptr0_q), .ptr1_q(ptr1_q), .bank_q(bank_q));
	bdma_sfr_model u_sfr (.clk_sys(clk_sys), .sfr_sel(sfr_sel),
		.sfr_wr(sfr_wr), .sfr_bank(sfr_bank), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
		.sfr_ro(sfr_ro));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	// expected byte after a single-bit write
	function automatic logic [7:0] set_bit(logic [7:0] v, int k, logic b);
		v[k] = b;
		return v;
	endfunction : set_bit
	// one access per cycle, held until the taking edge
	task automatic acc(logic rd, wr, logic [7:0] ad, wd, logic bo = 0);
		acc_rd = rd;
		acc_wr = wr;
		acc_addr = ad;
		acc_wdata = wd;
		bit_op = bo;
		@(posedge clk_sys);
		#1;
	endtask : acc
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 3000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 rst = 0;
		`CHK({ptr0_q, ptr1_q, bank_q}, 17'h0)
		acc(1, 0, BDMA_BANK_ADDR, 0);
		`CHK(acc_rdata, 8'h00)
		for (int i = 0; i < 128; i++) begin
			gp[i] = rnd();
			acc(0, 1, BDMA_GP_BASE | 8'(i), gp[i]);
		end
		acc(0, 1, BDMA_BANK_ADDR, 8'hff);
		acc(1, 0, BDMA_BANK_ADDR, 0);
		`CHK(acc_rdata, 8'h01)
		for (int i = 0; i < 20; i++) begin
			a = BDMA_GP_BASE | (rnd() & 8'h7f);
			acc(1, 0, a, 0);
			`CHK(acc_rdata, gp[a[6:0]])
			acc(0, 1, BDMA_PTR0_ADDR, a);
			`CHK(ptr0_q, a)
			acc(1, 0, BDMA_WIN0_ADDR, 0);
			`CHK(acc_rdata, gp[a[6:0]])
			d = rnd();
			acc(0, 1, BDMA_WIN0_ADDR, d);
			gp[a[6:0]] = d;
			acc(1, 0, a, 0);
			`CHK(acc_rdata, d)
			acc(0, 1, BDMA_PTR1_ADDR, a);
			acc(1, 0, BDMA_WIN1_ADDR, 0);
			`CHK(acc_rdata, 8'h00)
			acc(0, 1, BDMA_WIN1_ADDR, ~d);
		end
		acc(0, 1, BDMA_BANK_ADDR, 8'h00);
		acc(1, 0, BDMA_WIN1_ADDR, 0);
		`CHK(acc_rdata, gp[a[6:0]])
		for (int k = 0; k < 8; k++) begin
			bit_sel = 3'(k);
			bit_val = k[0];
			acc(0, 1, a, rnd(), 1);
			gp[a[6:0]] = set_bit(gp[a[6:0]], k, k[0]);
			acc(1, 0, a, 0);
			`CHK(acc_rdata, gp[a[6:0]])
		end
		acc(0, 1, BDMA_PTR1_ADDR, BDMA_WIN1_ADDR);
		acc(1, 0, BDMA_WIN1_ADDR, 0);
		`CHK(acc_rdata, 8'h00)
		d = rnd();
		acc(0, 1, a, d);
		acc(1, 0, a, 0);
		`CHK(acc_rdata, d)
		acc(1, 0, BDMA_PTR0_ADDR, 0);
		`CHK(acc_rdata, a)
		acc(1, 0, 8'h17, 0);
		acc(0, 0, 0, 0);
		`CHK(acc_rdata, 8'h00)
		acc(0, 1, 8'h07, d);
		acc(0, 1, 8'h08, 8'h52);
		acc(1, 0, 8'h07, 0);
		acc(0, 0, 0, 0);
		`CHK(acc_rdata, d)
		acc(1, 0, 8'h08, 0);
		acc(0, 0, 0, 0);
		`CHK(acc_rdata, 8'had)
		acc(0, 1, BDMA_BANK_ADDR, 8'h01);
		acc(0, 1, BDMA_PTR1_ADDR, BDMA_EEC_ADDR);
		acc(0, 1, BDMA_WIN1_ADDR, d);
		acc(0, 1, BDMA_EEC_ADDR, ~d);
		acc(1, 0, BDMA_WIN1_ADDR, 0);
		acc(0, 0, 0, 0);
		`CHK(acc_rdata, d)
		acc(1, 0, BDMA_EEC_ADDR, 0);
		acc(0, 0, 0, 0);
		`CHK(acc_rdata, 8'h00)
		acc(0, 1, BDMA_BANK_ADDR, 8'h01);
		acc(0, 0, 0, 0);
		rst = 1;
		wdt_sleep_rst = 1;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK(bank_q, 1'b1)
		wdt_sleep_rst = 0;
		@(posedge clk_sys);
		#1;
		`CHK(bank_q, 1'b0)
		results();
	end
endmodule : testbench
